/* hdl/mpg_consts.svh */
// register offsets, control field positions and reset values of the pwm generator
`ifndef MPG_CONSTS_SVH
`define MPG_CONSTS_SVH

// ==========================================================
// register byte offsets (low 12 address bits)
`define MPG_CTRL_OFS 12'h000
`define MPG_PERIOD_OFS 12'h004
`define MPG_STATUS_OFS 12'h008
`define MPG_DUTY_FIRST_OFS 12'h010
`define MPG_DUTY_LAST_OFS 12'h04C

// ==========================================================
// control register fields
`define MPG_CTRL_EN_BIT 0
`define MPG_CTRL_EDGE_BIT 1
`define MPG_CTRL_DBL_BIT 2
`define MPG_CTRL_PAIR_LSB 4
`define MPG_CTRL_PAIR_MSB 7

// ==========================================================
// reset values
`define MPG_PERIOD_RST 16'h0100
`define MPG_DUTY_RST 16'h0000

`endif

/* hdl/mpg_group.sv */
// one group of four pwm outputs: two pairs, paired or independent
`timescale 1ns/1ps
module mpg_group (
  input wire logic [15:0] cnt_i,
  input wire logic [15:0] per_i,
  input wire mpg_pkg::mpg_duty4_type duty_i,
  input wire logic paired_i,
  input wire logic center_i,
  output logic [3:0] pwm_o
);

  // ==========================================================
  // compare
  // center pulse grows out from the top of the triangle, so it is symmetric about mid-period
  function automatic logic cmp(input logic [15:0] cnt, input logic [15:0] per,
                               input logic [15:0] duty, input logic center);
    logic [16:0] sum;
    sum = {1'b0, cnt} + {1'b0, duty};
    if (center) begin
      cmp = (sum >= {1'b0, per});
    end else begin
      cmp = (cnt < duty);
    end
  endfunction

  logic on0;
  logic on1;
  logic on2;
  logic on3;

  always_comb begin
    on0 = cmp(cnt_i, per_i, duty_i[0], center_i);
    on1 = cmp(cnt_i, per_i, duty_i[1], center_i);
    on2 = cmp(cnt_i, per_i, duty_i[2], center_i);
    on3 = cmp(cnt_i, per_i, duty_i[3], center_i);
    if (paired_i) begin
      pwm_o = {~on2, on2, ~on0, on0};
    end else begin
      pwm_o = {on3, on2, on1, on0};
    end
  end

endmodule

/* hdl/mpg_pkg.sv */
// types shared by the pwm generator modules
package mpg_pkg;

  typedef logic [3:0][15:0] mpg_duty4_type;

  typedef struct packed {
    logic en;
    logic edge_al;
    logic dbl;
    logic [3:0] paired;
    logic [15:0] per_sh;
    logic [15:0] per_act;
    logic [15:0][15:0] duty_sh;
    logic [15:0][15:0] duty_act;
    logic [15:0] cnt;
    logic dir_down;
    logic dph_wr;
    logic dph_rd;
    logic rd_done;
    logic [11:0] dph_addr;
    logic [31:0] rdata;
    logic [15:0] pwm;
  } mpg_state_type;

endpackage

/* hdl/mpg_top.sv */
// pwm generator top: ahb-lite register slave, shared timebase, shadow update, 16 outputs
// Contract
// - software picks center-aligned or edge-aligned waveforms
// - paired mode drives each pair as complements from one duty value
// - nonpaired mode drives four outputs from own duties, chosen per group
// - four groups of four outputs, sixteen outputs in all
// - each group forms two pairs from its four outputs
// - center single update loads new duties once per period only
// - center double update also loads timing values at mid-period
// - single or double update only matters in center-aligned operation
`timescale 1ns/1ps
`include "mpg_consts.svh"
module mpg_top (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [15:0] pwm_o
);

  mpg_pkg::mpg_state_type s;
  mpg_pkg::mpg_state_type next_s;

  // ==========================================================
  // helpers
  function automatic logic [15:0] last_cnt(input logic [15:0] per);
    last_cnt = (per < 16'h0002) ? 16'h0000 : per - 16'h0001;
  endfunction

  function automatic logic is_duty(input logic [11:0] a);
    is_duty = (a >= `MPG_DUTY_FIRST_OFS) && (a <= `MPG_DUTY_LAST_OFS) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [3:0] duty_idx(input logic [11:0] a);
    logic [11:0] d;
    d = a - `MPG_DUTY_FIRST_OFS;
    duty_idx = d[5:2];
  endfunction

  // ==========================================================
  // timebase events
  logic [15:0] last;
  logic at_start;
  logic at_mid;
  logic load;
  logic accept;
  logic [15:0] grp_out;

  always_comb begin
    last = last_cnt(s.per_act);
    // >= in edge mode recovers if a mode switch leaves the count above the period
    at_start = s.edge_al ? (s.cnt >= last) : (s.dir_down && s.cnt == 16'h0000);
    at_mid = !s.edge_al && !s.dir_down && (s.cnt == last);
    // double update ignored in edge mode: at_mid never fires there
    load = !s.en || at_start || (at_mid && s.dbl);
    accept = hsel_i && htrans_i[1] && hready_i;
  end

  // ==========================================================
  // groups
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : grp
      mpg_group u_grp (
        .cnt_i(s.cnt),
        .per_i(s.per_act),
        .duty_i(s.duty_act[4*g+3 -: 4]),
        .paired_i(s.paired[g]),
        .center_i(!s.edge_al),
        .pwm_o(grp_out[4*g+3 -: 4])
      );
    end
  endgenerate

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;
    if (!s.en) begin
      next_s.cnt = 16'h0000;
      next_s.dir_down = 1'b0;
    end else if (s.edge_al) begin
      next_s.cnt = at_start ? 16'h0000 : s.cnt + 16'h0001;
      next_s.dir_down = 1'b0;
    end else if (!s.dir_down) begin
      if (s.cnt >= last) begin
        next_s.dir_down = 1'b1;
      end else begin
        next_s.cnt = s.cnt + 16'h0001;
      end
    end else begin
      if (s.cnt == 16'h0000) begin
        next_s.dir_down = 1'b0;
      end else begin
        next_s.cnt = s.cnt - 16'h0001;
      end
    end
    if (load) begin
      next_s.per_act = s.per_sh;
      next_s.duty_act = s.duty_sh;
    end
    next_s.pwm = s.en ? grp_out : 16'h0000;

    // bus data phase: writes take no wait, reads take one
    next_s.dph_wr = 1'b0;
    if (s.dph_wr) begin
      case (s.dph_addr)
        `MPG_CTRL_OFS: begin
          next_s.en = hwdata_i[`MPG_CTRL_EN_BIT];
          next_s.edge_al = hwdata_i[`MPG_CTRL_EDGE_BIT];
          next_s.dbl = hwdata_i[`MPG_CTRL_DBL_BIT];
          next_s.paired = hwdata_i[`MPG_CTRL_PAIR_MSB:`MPG_CTRL_PAIR_LSB];
        end
        `MPG_PERIOD_OFS: begin
          next_s.per_sh = hwdata_i[15:0];
        end
        default: begin
          if (is_duty(s.dph_addr)) begin
            next_s.duty_sh[duty_idx(s.dph_addr)] = hwdata_i[15:0];
          end
        end
      endcase
    end
    if (s.dph_rd && !s.rd_done) begin
      next_s.rd_done = 1'b1;
      case (s.dph_addr)
        `MPG_CTRL_OFS: begin
          next_s.rdata = {24'h000000, s.paired, 1'b0, s.dbl, s.edge_al, s.en};
        end
        `MPG_PERIOD_OFS: begin
          next_s.rdata = {16'h0000, s.per_sh};
        end
        `MPG_STATUS_OFS: begin
          next_s.rdata = {s.cnt, 15'h0000, s.dir_down};
        end
        default: begin
          if (is_duty(s.dph_addr)) begin
            next_s.rdata = {16'h0000, s.duty_sh[duty_idx(s.dph_addr)]};
          end else begin
            next_s.rdata = 32'h00000000;
          end
        end
      endcase
    end else if (s.rd_done) begin
      next_s.dph_rd = 1'b0;
      next_s.rd_done = 1'b0;
    end
    if (accept) begin
      next_s.dph_wr = hwrite_i;
      next_s.dph_rd = !hwrite_i;
      next_s.rd_done = 1'b0;
      next_s.dph_addr = haddr_i[11:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s <= '0;
      s.per_sh <= `MPG_PERIOD_RST;
      s.per_act <= `MPG_PERIOD_RST;
      s.duty_sh <= {16{`MPG_DUTY_RST}};
      s.duty_act <= {16{`MPG_DUTY_RST}};
    end else begin
      s <= next_s;
    end
  end

  assign hrdata_o = s.rdata;
  assign hreadyout_o = !(s.dph_rd && !s.rd_done);
  assign hresp_o = 1'b0;
  assign pwm_o = s.pwm;

  // ==========================================================
  // checks
  property p_edge_up;
    @(posedge mclk_i) disable iff (!rst_n_i)
    s.en && s.edge_al |=> !s.dir_down;
  endproperty
  a_edge_up: assert property (p_edge_up) else $error("edge mode counted down");

  property p_pair_a;
    @(posedge mclk_i) disable iff (!rst_n_i)
    $past(s.en) && $past(s.paired[0]) |-> pwm_o[1] == !pwm_o[0];
  endproperty
  a_pair_a: assert property (p_pair_a) else $error("group 0 pair not complementary");

  property p_pair_b;
    @(posedge mclk_i) disable iff (!rst_n_i)
    $past(s.en) && $past(s.paired[2]) |-> pwm_o[11] == !pwm_o[10];
  endproperty
  a_pair_b: assert property (p_pair_b) else $error("group 2 pair b not complementary");

  property p_indep;
    @(posedge mclk_i) disable iff (!rst_n_i)
    s.en && !s.paired[0] && s.edge_al |=> pwm_o[1] == ($past(s.cnt) < $past(s.duty_act[1]));
  endproperty
  a_indep: assert property (p_indep) else $error("independent output ignored own duty");

  property p_off;
    @(posedge mclk_i) disable iff (!rst_n_i)
    !s.en |=> pwm_o == 16'h0000;
  endproperty
  a_off: assert property (p_off) else $error("outputs active while disabled");

  property p_single;
    @(posedge mclk_i) disable iff (!rst_n_i)
    s.en && !s.edge_al && !s.dbl && !at_start |=> $stable(s.duty_act);
  endproperty
  a_single: assert property (p_single) else $error("duty changed mid-period");

  property p_double;
    @(posedge mclk_i) disable iff (!rst_n_i)
    s.en && !s.edge_al && s.dbl && at_mid |=> s.duty_act == $past(s.duty_sh);
  endproperty
  a_double: assert property (p_double) else $error("no midpoint load");

  property p_edge_nodbl;
    @(posedge mclk_i) disable iff (!rst_n_i)
    s.en && s.edge_al && s.dbl && !at_start |=> $stable(s.duty_act) && $stable(s.per_act);
  endproperty
  a_edge_nodbl: assert property (p_edge_nodbl) else $error("edge mode double loaded");

  property p_shadow;
    @(posedge mclk_i) disable iff (!rst_n_i)
    s.en && at_start |=> s.per_act == $past(s.per_sh) ##1 s.per_act == $past(s.per_act);
  endproperty
  a_shadow: assert property (p_shadow) else $error("period not applied at start");

  property p_rd_wait;
    @(posedge mclk_i) disable iff (!rst_n_i)
    !hreadyout_o |=> hreadyout_o;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait longer than one cycle");

  c_edge_wrap: cover property (@(posedge mclk_i) disable iff (!rst_n_i) s.en && s.edge_al && at_start);
  c_mid_load: cover property (@(posedge mclk_i) disable iff (!rst_n_i) s.en && s.dbl && at_mid);
  c_center_start: cover property (@(posedge mclk_i) disable iff (!rst_n_i) s.en && !s.edge_al && at_start);
  c_read: cover property (@(posedge mclk_i) disable iff (!rst_n_i) !hreadyout_o);

endmodule

/* verification/mpg_power_stage.sv */
// power stage model: counts the high cycles of every pwm output over a window
`timescale 1ns/1ps
module mpg_power_stage (
  input wire logic mclk_i,
  input wire logic meas_i,
  input wire logic [15:0] pwm_i,
  output logic [15:0][15:0] hi_cnt_o,
  output logic done_o
);
  logic meas_q = 1'b0;
  // ==========================================================
  // counting
  // a window of whole periods gives totals that do not depend on its start
  always @(posedge mclk_i) begin
    meas_q <= meas_i;
    done_o <= meas_q && !meas_i;
    for (int i = 0; i < 16; i++) begin
      if (meas_i && !meas_q)
        hi_cnt_o[i] <= {15'h0, pwm_i[i]};
      else if (meas_i)
        hi_cnt_o[i] <= hi_cnt_o[i] + {15'h0, pwm_i[i]};
    end
  end
endmodule

/* verification/testbench.sv */
// self-checking bench of the pwm generator
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin n_fail++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, s); end end
module testbench;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o;
  logic hreadyout_o;
  logic hresp_o;
  logic rd_phase = 1'b0;
  logic meas = 1'b0;
  logic done;
  logic [15:0] pwm_o;
  logic [15:0][15:0] hi_cnt;
  logic [15:0][15:0] duty;
  logic [31:0] exp_q[$];
  logic [31:0] e_v;
  logic [31:0] seed = 32'hEDF5;
  logic [7:0] modes[4] = '{8'h03, 8'h57, 8'hA1, 8'h05};
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;

  mpg_top dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .pwm_o(pwm_o));
  mpg_power_stage stage_u (.mclk_i(mclk_i), .meas_i(meas), .pwm_i(pwm_o),
    .hi_cnt_o(hi_cnt), .done_o(done));

  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic print_verdict();
    if (n_fail == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // one single ahb-lite transfer; waits on hready with no assumed latency
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    hsel_i <= 1'b1;
    haddr_i <= {20'h0, a};
    htrans_i <= 2'h2;
    hwrite_i <= wr;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    rd_phase <= !wr;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    rd_phase <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  // settle past an update point, then count over 32 cycles (4 edge or 2 center periods)
  task automatic measure(input logic [3:0] pr);
    logic [15:0] b;
    repeat (40) @(posedge mclk_i);
    for (int i = 0; i < 16; i++) begin
      b = (pr[i / 4] && i[0]) ? duty[i - 1] : duty[i];
      b = 16'h4 * ((b > 16'h8) ? 16'h8 : b);
      exp_q.push_back({16'h0, (pr[i / 4] && i[0]) ? 16'h20 - b : b});
    end
    meas <= 1'b1;
    repeat (32) @(posedge mclk_i);
    meas <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask

  // ==========================================================
  // clock, timeout and result watcher
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      print_verdict();
    end
  end

  always @(posedge mclk_i) begin
    if (rd_phase && hreadyout_o === 1'b1) begin
      e_v = exp_q.pop_front();
      `CHK("hrdata", e_v, hrdata_o)
      `CHK("hresp", 1'b0, hresp_o)
    end
    if (done === 1'b1) begin
      for (int i = 0; i < 16; i++) begin
        e_v = exp_q.pop_front();
        `CHK("high_cycles", e_v[15:0], hi_cnt[i])
      end
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd(12'h000, 32'h0);
    rd(12'h004, 32'h100);
    rd(12'h010, 32'h0);
    // disabled timebase rests at zero, counting up
    rd(12'h008, 32'h0);
    bus(1'b1, 12'h050, 32'hFFFF_FFFF);
    rd(12'h050, 32'h0);
    bus(1'b1, 12'h004, 32'hABCD_0008);
    rd(12'h004, 32'h8);
    for (int m = 0; m < 4; m++) begin
      // duties rewritten while running land in the shadows first
      for (int k = 0; k < 16; k++) begin
        seed = lfsr(seed);
        duty[k] = {12'h0, seed[3:0]};
        bus(1'b1, 12'h010 + 12'(4 * k), {seed[31:16], duty[k]});
      end
      bus(1'b1, 12'h000, {24'h0, modes[m]});
      rd(12'h000, {24'h0, modes[m]});
      measure(modes[m][7:4]);
    end
    rd(12'h04C, {16'h0, duty[15]});
    bus(1'b1, 12'h000, 32'hFFFF_FFFF);
    rd(12'h000, 32'hF7);
    repeat (5) @(posedge mclk_i);
    print_verdict();
  end
endmodule
